/* bce_pkg.sv */
// Constants, field layouts and types of the branch and CPU control execution block.
// Overview of operation
// - short direct bit set: clear, branch PC+4
// - SFR bit set: clear, branch PC+4, 12
// - accumulator bit set: clear, branch PC+3, 8
// - status word bit set: clear, PC+4
// - HL memory bit: PC+3, 10 or 12+n+m
// - B decremented, branch PC+2 if nonzero
// - C decremented, branch PC+2 if nonzero
// - short direct byte decremented, branch PC+3
// - interrupt enable op sets master enable
// - interrupt disable op clears master enable
// - one counted clock is one CPU clock
// - first column for fast RAM, no data
// - second column for any other data area
// - external reads add read wait states
// - external writes add write wait states
// - counts hold for internal ROM fetch only
// - accumulator forms reject accumulator as register
// - AX to pair only for BC, DE, HL
// - 8-bit group only with tabled operand pairings
// - word arithmetic only AX with immediate word
package bce_pkg;
  // ==========================================================================
  // Register map and control bits
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INSTR = 8'h04;
  localparam logic [7:0] A_OPND = 8'h08;
  localparam logic [7:0] A_WAIT = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_RES = 8'h14;
  localparam logic [7:0] A_CYC = 8'h18;
  localparam logic [7:0] A_CHK = 8'h1c;
  localparam logic [7:0] A_PSW = 8'h20;
  localparam int C_START = 0;
  localparam int C_WAKE = 1;
  localparam int C_PCC = 2;
  localparam int S_DONE = 1;
  localparam logic [2:0] PCC_MAX = 3'h4;
  localparam logic [2:0] PCC_RST = 3'h0;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam int P_CY = 0;
  localparam int P_RB0 = 3;
  localparam int P_AC = 4;
  localparam int P_RB1 = 5;
  localparam int P_Z = 6;
  localparam int P_IE = 7;
  // ==========================================================================
  // Operation codes, lengths and clock counts
  localparam logic [4:0] OP_BT_SADDR = 5'h00;
  localparam logic [4:0] OP_BT_SFR = 5'h01;
  localparam logic [4:0] OP_BT_A = 5'h02;
  localparam logic [4:0] OP_BT_PSW = 5'h03;
  localparam logic [4:0] OP_BT_HL = 5'h04;
  localparam logic [4:0] OP_DB_B = 5'h05;
  localparam logic [4:0] OP_DB_C = 5'h06;
  localparam logic [4:0] OP_DB_SADDR = 5'h07;
  localparam logic [4:0] OP_SEL = 5'h08;
  localparam logic [4:0] OP_NOP = 5'h09;
  localparam logic [4:0] OP_EI = 5'h0a;
  localparam logic [4:0] OP_DI = 5'h0b;
  localparam logic [4:0] OP_HALT = 5'h0c;
  localparam logic [4:0] OP_STOP = 5'h0d;
  localparam logic [15:0] L1 = 16'h0001;
  localparam logic [15:0] L2 = 16'h0002;
  localparam logic [15:0] L3 = 16'h0003;
  localparam logic [15:0] L4 = 16'h0004;
  localparam logic [7:0] K_BTS1 = 8'h0a;
  localparam logic [7:0] K_BTS2 = 8'h0c;
  localparam logic [7:0] K_BTSFR = 8'h0c;
  localparam logic [7:0] K_BTA = 8'h08;
  localparam logic [7:0] K_BTPSW = 8'h0c;
  localparam logic [7:0] K_BTHL1 = 8'h0a;
  localparam logic [7:0] K_BTHL2 = 8'h0c;
  localparam logic [7:0] K_DBR = 8'h06;
  localparam logic [7:0] K_DBS1 = 8'h08;
  localparam logic [7:0] K_DBS2 = 8'h0a;
  localparam logic [7:0] K_SEL = 8'h04;
  localparam logic [7:0] K_NOP = 8'h02;
  localparam logic [7:0] K_EIDI = 8'h06;
  localparam logic [7:0] K_STBY = 8'h06;
  // ==========================================================================
  // Operand legality checker codes
  localparam logic [3:0] G_MOV = 4'h0, G_XCH = 4'h1, G_ALU = 4'h2, G_INC = 4'h3;
  localparam logic [3:0] G_ROT = 4'h4, G_ROT4 = 4'h5, G_PP = 4'h6, G_MUL = 4'h7;
  localparam logic [3:0] G_DIV = 4'h8, G_DECREMENT_BRANCH_NONZERO = 4'h9, G_WORD_MOVE_OP = 4'ha, G_WORD_EXCHANGE_OP = 4'hb;
  localparam logic [3:0] G_ALUW = 4'hc, G_RPW = 4'hd;
  localparam logic [3:0] K_IMM = 4'h0, K_A = 4'h1, K_R = 4'h2, K_SFR = 4'h3;
  localparam logic [3:0] K_SADDR = 4'h4, K_ABS = 4'h5, K_PSW = 4'h6, K_DE = 4'h7;
  localparam logic [3:0] K_HL = 4'h8, K_HLX = 4'h9, K_REL = 4'ha, K_ONE = 4'hb;
  localparam logic [3:0] K_NONE = 4'hc, K_AX = 4'hd, K_RP = 4'he, K_SP = 4'hf;
  localparam logic [3:0] R_X = 4'h0, R_A = 4'h1, R_C = 4'h2, R_B = 4'h3, RP_AX = 4'h0;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_STANDBY} bce_state_e;
  typedef struct packed {
    logic [11:0] pad;
    logic expArea;
    logic notHsRam;
    logic [1:0] bankNumber;
    logic [7:0] branchDisplacement;
    logic [2:0] bitSel;
    logic [4:0] op;
  } bce_instr_s;
  typedef struct packed {
    logic [18:0] pad;
    logic extFetch;
    logic [3:0] fetchExtra;
    logic [3:0] wrWait;
    logic [3:0] rdWait;
  } bce_wait_s;
  typedef struct packed {
    logic [15:0] pad;
    logic [3:0] rg;
    logic [3:0] src;
    logic [3:0] dst;
    logic [3:0] grp;
  } bce_chk_s;
endpackage

/* bce_exec.sv */
// Execution unit for bit-test branches, loop branches and CPU control operations.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module bce_exec (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic masterIrqEnable,
  output logic [1:0] bankSelect,
  output logic haltMode,
  output logic stopMode,
  output logic busy
);
  // ==========================================================================
  // State
  bce_pkg::bce_state_e state;
  bce_pkg::bce_instr_s ins;
  bce_pkg::bce_wait_s wcfg;
  bce_pkg::bce_chk_s chk;
  logic [7:0] opByte, program_status_word, total, cnt, result;
  logic [15:0] pc, newPc;
  logic [2:0] processor_clock_control, pccEff;
  logic [3:0] divCnt, lim;
  logic done, illegal, taken, legalOk, loaded;
  logic wrEn, start, wake, tick, fin, unmapped;
  logic [7:0] next_total, next_res, next_psw, src, waits, fetchAdd;
  logic [15:0] next_pc, len, disp;
  logic next_taken, bitOn;
  logic [31:0] rdMux;

  // ==========================================================================
  // Bus slave
  // Without clkEn the bus stalls as well, so a frozen block never loses a write.
  assign pready = psel & penable & loaded & clkEn;
  assign wrEn = pready & pwrite;
  assign start = wrEn & (paddr == bce_pkg::A_CTRL) & pwdata[bce_pkg::C_START];
  assign wake = wrEn & (paddr == bce_pkg::A_CTRL) & pwdata[bce_pkg::C_WAKE];

  always_comb begin
    unmapped = 1'b0;
    case (paddr)
      bce_pkg::A_CTRL: rdMux = {27'h0, processor_clock_control, 2'h0};
      bce_pkg::A_INSTR: rdMux = ins;
      bce_pkg::A_OPND: rdMux = {8'h00, pc, opByte};
      bce_pkg::A_WAIT: rdMux = wcfg;
      bce_pkg::A_STAT: rdMux = {22'h0, legalOk, bankSelect, masterIrqEnable,
                                stopMode, haltMode, taken, illegal, done, busy};
      bce_pkg::A_RES: rdMux = {8'h00, newPc, result};
      bce_pkg::A_CYC: rdMux = {24'h0, total};
      bce_pkg::A_CHK: rdMux = chk;
      bce_pkg::A_PSW: rdMux = {24'h0, program_status_word};
      default: begin
        rdMux = 32'h0;
        unmapped = 1'b1;
      end
    endcase
  end

  // Read data is captured in the setup cycle so that it leaves a flip-flop.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      loaded <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      if (psel & penable & loaded) begin
        loaded <= 1'b0;
      end else if (psel) begin
        loaded <= 1'b1;
        prdata <= rdMux;
        pslverr <= unmapped;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ins <= '0;
      wcfg <= '0;
      pc <= 16'h0000;
      opByte <= 8'h00;
      processor_clock_control <= bce_pkg::PCC_RST;
      chk <= '0;
    end else if (wrEn) begin
      case (paddr)
        bce_pkg::A_CTRL: processor_clock_control <= pwdata[bce_pkg::C_PCC +: 3];
        bce_pkg::A_INSTR: ins <= pwdata;
        bce_pkg::A_OPND: begin
          opByte <= pwdata[7:0];
          pc <= pwdata[23:8];
        end
        bce_pkg::A_WAIT: wcfg <= {19'h0, pwdata[12:0]};
        bce_pkg::A_CHK: chk <= {16'h0, pwdata[15:0]};
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // CPU clock divider
  // The divider runs free, so the first counted clock of an operation may be
  // short by up to one divided period; the total count is unaffected.
  // Selections above the slowest divider are clamped, never wrapped to a fast one.
  assign pccEff = (processor_clock_control > bce_pkg::PCC_MAX) ? bce_pkg::PCC_MAX : processor_clock_control;
  assign lim = 4'((5'h01 << pccEff) - 5'h01);
  assign tick = (divCnt == lim);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      divCnt <= 4'h0;
    end else if (clkEn) begin
      divCnt <= tick ? 4'h0 : divCnt + 4'h1;
    end
  end

  // ==========================================================================
  // Clock count of the operation being started
  always_comb begin
    // Wait states only count when the data lands in the expansion area.
    waits = ins.expArea ? ({4'h0, wcfg.rdWait} + {4'h0, wcfg.wrWait}) : 8'h00;
    fetchAdd = wcfg.extFetch ? {4'h0, wcfg.fetchExtra} : 8'h00;
    case (ins.op)
      bce_pkg::OP_BT_SADDR: next_total = ins.notHsRam ? bce_pkg::K_BTS2 + waits : bce_pkg::K_BTS1;
      bce_pkg::OP_BT_SFR: next_total = bce_pkg::K_BTSFR;
      bce_pkg::OP_BT_A: next_total = bce_pkg::K_BTA;
      bce_pkg::OP_BT_PSW: next_total = bce_pkg::K_BTPSW;
      bce_pkg::OP_BT_HL: next_total = ins.notHsRam ? bce_pkg::K_BTHL2 + waits : bce_pkg::K_BTHL1;
      bce_pkg::OP_DB_B: next_total = bce_pkg::K_DBR;
      bce_pkg::OP_DB_C: next_total = bce_pkg::K_DBR;
      bce_pkg::OP_DB_SADDR: next_total = ins.notHsRam ? bce_pkg::K_DBS2 + waits : bce_pkg::K_DBS1;
      bce_pkg::OP_SEL: next_total = bce_pkg::K_SEL;
      bce_pkg::OP_NOP: next_total = bce_pkg::K_NOP;
      bce_pkg::OP_EI: next_total = bce_pkg::K_EIDI;
      bce_pkg::OP_DI: next_total = bce_pkg::K_EIDI;
      default: next_total = bce_pkg::K_STBY;
    endcase
    next_total = next_total + fetchAdd;
  end

  // ==========================================================================
  // Operation effects, applied when the last clock ends
  always_comb begin
    // Results are worked out all the time and committed only on fin.
    src = (ins.op == bce_pkg::OP_BT_PSW) ? program_status_word : opByte;
    bitOn = src[ins.bitSel];
    disp = {{8{ins.branchDisplacement[7]}}, ins.branchDisplacement};
    next_res = src;
    next_taken = 1'b0;
    next_psw = program_status_word;
    len = bce_pkg::L2;
    case (ins.op)
      bce_pkg::OP_BT_SADDR, bce_pkg::OP_BT_SFR, bce_pkg::OP_BT_PSW,
      bce_pkg::OP_BT_A, bce_pkg::OP_BT_HL: begin
        next_taken = bitOn;
        next_res = src & ~(8'h01 << ins.bitSel);
        len = (ins.op == bce_pkg::OP_BT_A || ins.op == bce_pkg::OP_BT_HL) ? bce_pkg::L3 : bce_pkg::L4;
        if (ins.op == bce_pkg::OP_BT_PSW && bitOn) begin
          next_psw = next_res;
        end
      end
      bce_pkg::OP_DB_B, bce_pkg::OP_DB_C, bce_pkg::OP_DB_SADDR: begin
        next_res = opByte - 8'h01;
        next_taken = (next_res != 8'h00);
        len = (ins.op == bce_pkg::OP_DB_SADDR) ? bce_pkg::L3 : bce_pkg::L2;
      end
      bce_pkg::OP_SEL: begin
        next_psw[bce_pkg::P_RB1] = ins.bankNumber[1];
        next_psw[bce_pkg::P_RB0] = ins.bankNumber[0];
      end
      bce_pkg::OP_NOP: len = bce_pkg::L1;
      bce_pkg::OP_EI: next_psw[bce_pkg::P_IE] = 1'b1;
      bce_pkg::OP_DI: next_psw[bce_pkg::P_IE] = 1'b0;
      default: begin
      end
    endcase
    next_pc = pc + len + (next_taken ? disp : 16'h0000);
  end

  // ==========================================================================
  // Sequencer
  assign busy = (state == bce_pkg::ST_EXEC);
  assign fin = clkEn & busy & tick & ((cnt + 8'h01) == total);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= bce_pkg::ST_IDLE;
      cnt <= 8'h00;
      total <= 8'h00;
      illegal <= 1'b0;
    end else if (clkEn) begin
      case (state)
        bce_pkg::ST_IDLE: begin
          if (start) begin
            // An unknown code is flagged and never run, so the count of the last operation stays in place.
            illegal <= (ins.op > bce_pkg::OP_STOP);
            if (ins.op <= bce_pkg::OP_STOP) begin
              state <= bce_pkg::ST_EXEC;
              cnt <= 8'h00;
              total <= next_total;
            end
          end
        end
        bce_pkg::ST_EXEC: begin
          if (fin) begin
            state <= (ins.op == bce_pkg::OP_HALT || ins.op == bce_pkg::OP_STOP) ?
                     bce_pkg::ST_STANDBY : bce_pkg::ST_IDLE;
          end else if (tick) begin
            cnt <= cnt + 8'h01;
          end
        end
        bce_pkg::ST_STANDBY: begin
          if (wake) begin
            state <= bce_pkg::ST_IDLE;
          end
        end
        default: state <= bce_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      result <= 8'h00;
      newPc <= 16'h0000;
      taken <= 1'b0;
    end else if (fin) begin
      result <= next_res;
      newPc <= next_pc;
      taken <= next_taken;
    end
  end

  // A completion in the same cycle as a software write to the status word wins.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      program_status_word <= bce_pkg::PSW_RST;
    end else if (fin) begin
      program_status_word <= next_psw;
    end else if (wrEn && paddr == bce_pkg::A_PSW) begin
      program_status_word <= pwdata[7:0];
    end
  end

  assign masterIrqEnable = program_status_word[bce_pkg::P_IE];
  assign bankSelect = {program_status_word[bce_pkg::P_RB1], program_status_word[bce_pkg::P_RB0]};

  // Completion flag is sticky; a new completion beats a write-one clear.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done <= 1'b0;
    end else if (fin) begin
      done <= 1'b1;
    end else if (wrEn && paddr == bce_pkg::A_STAT && pwdata[bce_pkg::S_DONE]) begin
      done <= 1'b0;
    end
  end

  // Release from standby is decided outside; software reports it with wake.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      haltMode <= 1'b0;
      stopMode <= 1'b0;
    end else if (fin) begin
      haltMode <= (ins.op == bce_pkg::OP_HALT);
      stopMode <= (ins.op == bce_pkg::OP_STOP);
    end else if (clkEn && wake && state == bce_pkg::ST_STANDBY) begin
      haltMode <= 1'b0;
      stopMode <= 1'b0;
    end
  end

  // ==========================================================================
  // Operand pairing checker
  // It only answers software queries; it never gates execution.
  function automatic logic legalFn(input bce_pkg::bce_chk_s c);
    logic rNotA;
    rNotA = (c.src == bce_pkg::K_R) && (c.rg != bce_pkg::R_A);
    case (c.grp)
      bce_pkg::G_MOV: begin
        case (c.dst)
          bce_pkg::K_A: legalFn = rNotA || (c.src inside {bce_pkg::K_IMM, bce_pkg::K_SFR,
            bce_pkg::K_SADDR, bce_pkg::K_ABS, bce_pkg::K_PSW, bce_pkg::K_DE, bce_pkg::K_HL,
            bce_pkg::K_HLX});
          bce_pkg::K_R: legalFn = (c.rg != bce_pkg::R_A) && (c.src inside {bce_pkg::K_IMM, bce_pkg::K_A});
          bce_pkg::K_SFR, bce_pkg::K_SADDR, bce_pkg::K_PSW:
            legalFn = c.src inside {bce_pkg::K_IMM, bce_pkg::K_A};
          bce_pkg::K_ABS, bce_pkg::K_DE, bce_pkg::K_HL, bce_pkg::K_HLX:
            legalFn = (c.src == bce_pkg::K_A);
          default: legalFn = 1'b0;
        endcase
      end
      bce_pkg::G_XCH: legalFn = (c.dst == bce_pkg::K_A) && (rNotA || (c.src inside {bce_pkg::K_SFR,
        bce_pkg::K_SADDR, bce_pkg::K_ABS, bce_pkg::K_DE, bce_pkg::K_HL, bce_pkg::K_HLX}));
      bce_pkg::G_ALU: legalFn = ((c.dst == bce_pkg::K_A) && (rNotA || (c.src inside {bce_pkg::K_IMM,
        bce_pkg::K_SADDR, bce_pkg::K_ABS, bce_pkg::K_HL, bce_pkg::K_HLX})))
        || ((c.dst == bce_pkg::K_R) && (c.src == bce_pkg::K_A) && (c.rg != bce_pkg::R_A))
        || ((c.dst == bce_pkg::K_SADDR) && (c.src == bce_pkg::K_IMM));
      bce_pkg::G_INC: legalFn = (c.src == bce_pkg::K_NONE) && (c.dst inside {bce_pkg::K_R, bce_pkg::K_SADDR});
      bce_pkg::G_ROT: legalFn = (c.dst == bce_pkg::K_A) && (c.src == bce_pkg::K_ONE);
      bce_pkg::G_ROT4: legalFn = (c.dst == bce_pkg::K_HL) && (c.src == bce_pkg::K_NONE);
      bce_pkg::G_PP: legalFn = (c.dst == bce_pkg::K_PSW) && (c.src == bce_pkg::K_NONE);
      bce_pkg::G_MUL: legalFn = (c.dst == bce_pkg::K_R) && (c.rg == bce_pkg::R_X) && (c.src == bce_pkg::K_NONE);
      bce_pkg::G_DIV: legalFn = (c.dst == bce_pkg::K_R) && (c.rg == bce_pkg::R_C) && (c.src == bce_pkg::K_NONE);
      bce_pkg::G_DECREMENT_BRANCH_NONZERO: legalFn = (c.src == bce_pkg::K_REL) && ((c.dst == bce_pkg::K_SADDR)
        || ((c.dst == bce_pkg::K_R) && (c.rg inside {bce_pkg::R_B, bce_pkg::R_C})));
      bce_pkg::G_WORD_MOVE_OP: legalFn = ((c.dst == bce_pkg::K_AX) && ((c.src inside {bce_pkg::K_SFR,
        bce_pkg::K_SADDR, bce_pkg::K_ABS, bce_pkg::K_SP})
        || ((c.src == bce_pkg::K_RP) && (c.rg != bce_pkg::RP_AX))))
        || ((c.dst == bce_pkg::K_RP) && ((c.src == bce_pkg::K_IMM)
        || ((c.src == bce_pkg::K_AX) && (c.rg != bce_pkg::RP_AX) && (c.rg < 4'h4))))
        || ((c.dst inside {bce_pkg::K_SFR, bce_pkg::K_SADDR, bce_pkg::K_SP})
        && (c.src inside {bce_pkg::K_IMM, bce_pkg::K_AX}))
        || ((c.dst == bce_pkg::K_ABS) && (c.src == bce_pkg::K_AX));
      bce_pkg::G_WORD_EXCHANGE_OP: legalFn = (c.dst == bce_pkg::K_AX) && (c.src == bce_pkg::K_RP) && (c.rg != bce_pkg::RP_AX);
      bce_pkg::G_ALUW: legalFn = (c.dst == bce_pkg::K_AX) && (c.src == bce_pkg::K_IMM);
      bce_pkg::G_RPW: legalFn = (c.dst == bce_pkg::K_RP) && (c.src == bce_pkg::K_NONE);
      default: legalFn = 1'b0;
    endcase
  endfunction

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      legalOk <= 1'b0;
    end else if (clkEn) begin
      legalOk <= legalFn(chk);
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_bit_test_clear_branch_saddr_pc: assert property (fin && ins.op == bce_pkg::OP_BT_SADDR && bitOn |=>
    newPc == $past(pc) + 16'h0004 + $past(disp) && taken) else $error("short direct branch target wrong");
  a_bit_test_clear_branch_bit_clear: assert property (fin && ins.op == bce_pkg::OP_BT_A && bitOn |=>
    result == ($past(opByte) & ~(8'h01 << $past(ins.bitSel)))) else $error("tested bit not cleared");
  a_bit_test_clear_branch_psw_clear: assert property (fin && ins.op == bce_pkg::OP_BT_PSW && bitOn |=>
    program_status_word[$past(ins.bitSel)] == 1'b0) else $error("status bit not cleared");
  a_hl_wait_count: assert property (start && !busy && ins.op == bce_pkg::OP_BT_HL && ins.notHsRam
    && ins.expArea && !wcfg.extFetch |=> total == 8'h0c + wcfg.rdWait + wcfg.wrWait)
    else $error("wait states not added");
  a_decrement_branch_nonzero_b_loop: assert property (fin && ins.op == bce_pkg::OP_DB_B |=> result == $past(opByte) - 8'h01
    && taken == (result != 8'h00)) else $error("loop decrement wrong");
  a_ei_sets_ie: assert property (fin && ins.op == bce_pkg::OP_EI |=> masterIrqEnable)
    else $error("enable not set");
  a_di_clears_ie: assert property (fin && ins.op == bce_pkg::OP_DI |=> !masterIrqEnable)
    else $error("enable not cleared");
  a_sel_bank: assert property (fin && ins.op == bce_pkg::OP_SEL |=> bankSelect == $past(ins.bankNumber))
    else $error("bank not selected");
  a_halt_standby: assert property (fin && ins.op == bce_pkg::OP_HALT |=> state == bce_pkg::ST_STANDBY
    && haltMode && !stopMode ##1 (!wake && clkEn) [*2] |-> haltMode) else $error("standby not held");
  a_tick_spacing: assert property (clkEn && tick && pccEff == 3'h1 ##1 clkEn |-> !tick)
    else $error("cpu clock too fast");
  a_nop_first_col: assert property (start && !busy && ins.op == bce_pkg::OP_NOP && !wcfg.extFetch |=>
    total == 8'h02) else $error("no-op count wrong");
  a_word_alu_pair: assert property (chk.grp == bce_pkg::G_ALUW && chk.src != bce_pkg::K_IMM && clkEn
    |=> !legalOk) else $error("word arithmetic pairing accepted");
  a_freeze_count: assert property (!clkEn |=> $stable(cnt) && $stable(state) && $stable(divCnt))
    else $error("state moved while clock enable low");

  c_bit_test_clear_branch_taken: cover property (fin && ins.op == bce_pkg::OP_BT_HL && bitOn);
  c_decrement_branch_nonzero_exit: cover property (fin && ins.op == bce_pkg::OP_DB_C && !next_taken);
  c_stop_wake: cover property (state == bce_pkg::ST_STANDBY && stopMode ##[1:50] state == bce_pkg::ST_IDLE);
  // A slow divider and a frozen operation stretch an operation in time without changing its count.
  c_slow_cpu_clock: cover property (fin && pccEff == 3'h1);
  c_frozen_exec: cover property (busy && !clkEn);
endmodule

/* bce_mem_model.sv */
// Behavioural model of the slow external expansion memory that stands behind the block.
`timescale 1ns/1ps
module bce_mem_model #(
  parameter logic [3:0] RD_WAITS = 4'h2,
  parameter logic [3:0] WR_WAITS = 4'h3
) (
  output bce_pkg::bce_wait_s waitWord
);
  // ==========================================================================
  // Wait settings
  // Reads and writes stall by different amounts, so dropping either term shows up in the count; a swap leaves the sum unchanged.
  assign waitWord = '{pad: 19'h0, extFetch: 1'b0, fetchExtra: 4'h0, wrWait: WR_WAITS, rdWait: RD_WAITS};
endmodule

/* tb_top.sv */
// Self-checking bench for the branch and CPU control execution block.
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, errFlag, masterIrqEnable, haltMode, stopMode, busy;
  logic [1:0] bankSelect;
  bce_pkg::bce_wait_s memWait;
  int errors = 0;
  int n_checks = 0;
  // ==========================================================================
  // Operation table: instruction, operand, result and base clock count
  localparam logic [31:0] INS [8] = '{32'h0000fe62, 32'h000c1004, 32'h00040620, 32'h00000005,
    32'h00008006, 32'h000c0207, 32'h000404e1, 32'h00000009};
  localparam logic [31:0] OPD [8] = '{32'h00100008, 32'h00200001, 32'h00300003, 32'h00400001,
    32'h00010005, 32'h00500003, 32'h00600070, 32'h0};
  localparam logic [23:0] RES [8] = '{24'h100100, 24'h201300, 24'h300a01, 24'h400200,
    24'h008204, 24'h500502, 24'h600470, 24'h0};
  localparam logic [7:0] CYC [8] = '{8'h08, 8'h0c, 8'h0c, 8'h06, 8'h06, 8'h0a, 8'h0c, 8'h05};
  localparam logic [7:0] EXT = 8'h22;
  localparam logic [15:0] CHKV [6] = '{16'h1212, 16'h0212, 16'h0dea, 16'h1dea, 16'h00dc, 16'h02dc};
  localparam logic [5:0] LEG = 6'b011010;
  always #10 clock = ~clock;
  bce_exec u_bce_exec (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .masterIrqEnable(masterIrqEnable), .bankSelect(bankSelect), .haltMode(haltMode), .stopMode(stopMode),
    .busy(busy));
  bce_mem_model u_bce_mem_model (.waitWord(memWait));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    errFlag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [31:0] ins, input logic [31:0] opd, input logic [31:0] wt);
    int k;
    apb(1'b1, bce_pkg::A_INSTR, ins);
    apb(1'b1, bce_pkg::A_OPND, opd);
    apb(1'b1, bce_pkg::A_WAIT, wt);
    apb(1'b1, bce_pkg::A_CTRL, 32'h1);
    for (k = 0; k < 100; k++) begin
      apb(1'b0, bce_pkg::A_STAT, 32'h0);
      if (rd[bce_pkg::S_DONE] === 1'b1) break;
    end
    chk("done", {31'h0, rd[bce_pkg::S_DONE]}, 32'h1);
    apb(1'b1, bce_pkg::A_STAT, 32'h2);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    apb(1'b0, bce_pkg::A_PSW, 32'h0);
    chk("status word", rd, 32'h0);
    chk("bank", {30'h0, bankSelect}, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_branch();
    int i;
    logic [7:0] w;
    for (i = 0; i < 8; i++) begin
      w = EXT[i] ? {4'h0, memWait.rdWait} + {4'h0, memWait.wrWait} : 8'h00;
      run(INS[i], OPD[i], EXT[i] ? memWait : (i == 7 ? 32'h1300 : 32'h0));
      apb(1'b0, bce_pkg::A_RES, 32'h0);
      if (i < 7) chk("result", {8'h0, rd[23:0]}, {8'h0, RES[i]});
      apb(1'b0, bce_pkg::A_CYC, 32'h0);
      chk("clocks", {24'h0, rd[7:0]}, {24'h0, CYC[i] + w});
    end
    $display("branch test done");
  endtask
  task automatic t_control();
    run(32'h0004000a, 32'h0, 32'h0);
    chk("irq enable", {31'h0, masterIrqEnable}, 32'h1);
    run(32'h0004000b, 32'h0, 32'h0);
    chk("irq enable", {31'h0, masterIrqEnable}, 32'h0);
    run(32'h00030008, 32'h0, 32'h0);
    chk("bank", {30'h0, bankSelect}, 32'h3);
    apb(1'b1, bce_pkg::A_PSW, 32'h11);
    run(32'h00040003, 32'h00700000, 32'h0);
    apb(1'b0, bce_pkg::A_PSW, 32'h0);
    chk("status word", {24'h0, rd[7:0]}, 32'h10);
    apb(1'b0, bce_pkg::A_RES, 32'h0);
    chk("status branch", {16'h0, rd[23:8]}, 32'h7004);
    run(32'h0000000c, 32'h0, 32'h0);
    chk("halt", {31'h0, haltMode}, 32'h1);
    apb(1'b1, bce_pkg::A_CTRL, 32'h2);
    repeat (2) @(posedge clock);
    chk("halt", {31'h0, haltMode}, 32'h0);
    run(32'h0000000d, 32'h0, 32'h0);
    chk("stop", {31'h0, stopMode}, 32'h1);
    apb(1'b1, bce_pkg::A_CTRL, 32'h2);
    repeat (2) @(posedge clock);
    chk("stop", {31'h0, stopMode}, 32'h0);
    $display("control test done");
  endtask
  task automatic t_clock();
    int n;
    apb(1'b1, bce_pkg::A_INSTR, 32'h9);
    apb(1'b1, bce_pkg::A_WAIT, 32'h0);
    apb(1'b1, bce_pkg::A_CTRL, 32'h5);
    n = 0;
    @(negedge clock);
    while (busy === 1'b1) begin
      n++;
      @(posedge clock);
      clkEn <= (n > 3);
      @(negedge clock);
    end
    chk("busy span", n, {24'h0, bce_pkg::K_NOP << 1} + 32'h3);
    apb(1'b1, bce_pkg::A_STAT, 32'h2);
    $display("clock test done");
  endtask
  task automatic t_legal();
    int i;
    for (i = 0; i < 6; i++) begin
      apb(1'b1, bce_pkg::A_CHK, {16'h0, CHKV[i]});
      apb(1'b0, bce_pkg::A_STAT, 32'h0);
      chk("operand pairing", {31'h0, rd[9]}, {31'h0, LEG[i]});
    end
    apb(1'b0, 8'h30, 32'h0);
    chk("slave error", {31'h0, errFlag}, 32'h1);
    $display("pairing test done");
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_branch();
    t_control();
    t_clock();
    t_legal();
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    wrap_up();
  end
endmodule
